// [dbs_core.sv]
// Command sequencer of a common-I/O DDR burst-of-two synchronous SRAM.
// Assumes core_clk_i runs at twice the K rate, aligned so that the first
// cycle after reset is a K rise; the partner controller is logic on the
// same clock and drives DQ only while dq_oe_o is low.
// Operation
// - Reads are referenced to cycle t and writes to t+1; all data phases count from the command edge.
// - A low load strobe with the select high on a K rise starts a read.
// - A low load strobe with the select low on a K rise starts a write.
// - A high load strobe on a K rise is a no-operation and leaves DQ undriven.
// - The first read word is driven 1.5 K cycles after the read command.
// - The second read word follows at 2.0 K cycles.
// - With the clocks stopped all state and outputs hold; pending work must finish first.
// - In x18 form lane enables 0 and 1 gate bits 0-8 and 9-17 per beat; both high aborts the beat.
// - In x36 form lane enables 0 to 3 gate the four 9-bit lanes per beat; all high aborts the beat.
// - An address is taken only with the load strobe low; a no-operation does not cut a read short.
// - The burst is two-word linear: start lsb 0 goes on to 1, start lsb 1 goes on to 0.
// - Reads of the last two write addresses return the buffered write data.
// - With both output clocks tied high, read data is timed from K and K# instead.
`timescale 1ns/1ns
`default_nettype none
module dbs_core import dbs_pkg::*; (
  input  wire logic              core_clk_i,
  input  wire logic              srst_i,
  input  wire logic              clk_en_i,
  input  wire logic              load_new_address_n_i,
  input  wire logic              read_not_write_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              byte_lane0_write_en_n_i,
  input  wire logic              byte_lane1_write_en_n_i,
  input  wire logic              byte_lane2_write_en_n_i,
  input  wire logic              byte_lane3_write_en_n_i,
  input  wire logic [DQ_W-1:0]   dq_i,
  input  wire logic              c_i,
  input  wire logic              c_n_i,
  input  wire logic              out_clk_tied_high_i,
  input  wire logic              org_x18_i,
  output logic      [DQ_W-1:0]   dq_o,
  output logic                   dq_oe_o,
  output logic                   k_rise_phase_o,
  output logic                   read_ready_o
);
  dbs_store_if sif ();

  // Phase and strap state
  logic phase_reg, phase_next;
  logic k_mode_reg, k_mode_next;
  logic x18_reg, x18_next;
  logic c_q_reg, c_q_next, cn_q_reg, cn_q_next;

  // Read schedule and output stage
  logic [RD_SECOND_CYC-1:0] rd_pipe_reg, rd_pipe_next;
  logic [DQ_W-1:0]          dq_reg, dq_next;
  logic                     oe_reg, oe_next;

  // Write schedule and first-beat hold
  logic [WR_SECOND_CYC-1:0] wv_reg, wv_next;
  logic [ADDR_W-1:0]        wa_reg  [0:WR_SECOND_CYC-1];
  logic [ADDR_W-1:0]        wa_next [0:WR_SECOND_CYC-1];
  logic [DQ_W-1:0]          b0_dat_reg, b0_dat_next;
  logic [LANES-1:0]         b0_msk_reg, b0_msk_next;

  logic               cmd_edge, rd_cmd, wr_cmd, rd_take;
  logic               fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [BURST_W-1:0] fifo_front, rd_burst;
  logic [ADDR_W-1:0]  addr_eff, wr_addr_done;
  logic [LANES-1:0]   lane_n, lanes_now;
  logic [DQ_W-1:0]    dq_in_eff;
  logic               launch0, launch1, c_rise, cn_rise;

  // Commands are only looked at on K rises
  assign cmd_edge = clk_en_i & ~phase_reg;
  assign rd_cmd   = cmd_edge & ~load_new_address_n_i & read_not_write_i;
  assign wr_cmd   = cmd_edge & ~load_new_address_n_i & ~read_not_write_i;
  // A refused read is dropped, so the controller must watch read_ready_o
  assign rd_take  = rd_cmd & fifo_in_ready;
  assign read_ready_o   = fifo_in_ready;
  assign k_rise_phase_o = ~phase_reg;

  // x36 form ignores the top address bit
  assign addr_eff = x18_reg ? addr_i : {1'b0, addr_i[ADDR_W-2:0]};
  assign lane_n   = {byte_lane3_write_en_n_i, byte_lane2_write_en_n_i,
                     byte_lane1_write_en_n_i, byte_lane0_write_en_n_i};
  assign lanes_now = lane_enables(lane_n, x18_reg);
  assign dq_in_eff = x18_reg ? {{(DQ_W-X18_W){1'b0}}, dq_i[X18_W-1:0]}
                             : dq_i;

  // Phase toggles every enabled core cycle; straps are caught while in reset
  always_comb begin
    phase_next  = clk_en_i ? ~phase_reg : phase_reg;
    k_mode_next = k_mode_reg;
    x18_next    = x18_reg;
    c_q_next    = clk_en_i ? c_i : c_q_reg;
    cn_q_next   = clk_en_i ? c_n_i : cn_q_reg;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      phase_reg  <= 1'b0;
      k_mode_reg <= out_clk_tied_high_i;
      x18_reg    <= org_x18_i;
      c_q_reg    <= 1'b1;
      cn_q_reg   <= 1'b1;
    end else begin
      phase_reg  <= phase_next;
      k_mode_reg <= k_mode_next;
      x18_reg    <= x18_next;
      c_q_reg    <= c_q_next;
      cn_q_reg   <= cn_q_next;
    end
  end

  // Output clock rises, used only when C and C# are really running
  assign c_rise  = c_i & ~c_q_reg;
  assign cn_rise = c_n_i & ~cn_q_reg;

  // Fetch both words of the row at the command edge, in beat order
  assign sif.rd_row = addr_eff[ADDR_W-1:1];
  assign rd_burst   = order_beats(addr_eff[0], sif.rd_data);

  dbs_fifo #(
    .WIDTH (BURST_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rd_fifo (
    .clk_i       (core_clk_i),
    .srst_i      (srst_i),
    .ce_i        (clk_en_i),
    .in_valid_i  (rd_take),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (rd_burst),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_front)
  );

  // Launch slots fall at fixed offsets from the read command edge
  assign launch0  = rd_pipe_reg[RD_FIRST_CYC-1] & fifo_out_valid
                    & (k_mode_reg | cn_rise);
  assign launch1  = rd_pipe_reg[RD_SECOND_CYC-1] & fifo_out_valid
                    & (k_mode_reg | c_rise);
  assign fifo_pop = rd_pipe_reg[RD_SECOND_CYC-1];

  // Read schedule shifts every enabled core cycle; a NOP adds nothing to it
  always_comb begin
    rd_pipe_next = rd_pipe_reg;
    dq_next      = dq_reg;
    oe_next      = oe_reg;
    if (clk_en_i) begin
      rd_pipe_next = {rd_pipe_reg[RD_SECOND_CYC-2:0], rd_take};
      if (launch0) begin
        dq_next = fifo_front[DQ_W-1:0];
      end else if (launch1) begin
        dq_next = fifo_front[BURST_W-1:DQ_W];
      end
      // Drive only across the two read beats, else stay off the bus
      oe_next = rd_pipe_reg[RD_FIRST_CYC-1]
                | rd_pipe_reg[RD_SECOND_CYC-1];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rd_pipe_reg <= '0;
      dq_reg      <= DQ_RST;
      oe_reg      <= 1'b0;
    end else begin
      rd_pipe_reg <= rd_pipe_next;
      dq_reg      <= dq_next;
      oe_reg      <= oe_next;
    end
  end

  assign dq_o    = dq_reg;
  assign dq_oe_o = oe_reg;

  // Write schedule: address rides along until its data arrives
  always_comb begin
    wv_next     = wv_reg;
    b0_dat_next = b0_dat_reg;
    b0_msk_next = b0_msk_reg;
    for (int i = 0; i < WR_SECOND_CYC; i++) begin
      wa_next[i] = wa_reg[i];
    end
    if (clk_en_i) begin
      wv_next    = {wv_reg[WR_SECOND_CYC-2:0], wr_cmd};
      wa_next[0] = wr_cmd ? addr_eff : ADDR_RST;
      for (int i = 1; i < WR_SECOND_CYC; i++) begin
        wa_next[i] = wa_reg[i-1];
      end
      // First beat taken on the K rise three cycles after the command
      if (wv_reg[WR_FIRST_CYC-1]) begin
        b0_dat_next = dq_in_eff;
        b0_msk_next = lanes_now;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wv_reg     <= '0;
      b0_dat_reg <= DQ_RST;
      b0_msk_reg <= '0;
      for (int i = 0; i < WR_SECOND_CYC; i++) begin
        wa_reg[i] <= ADDR_RST;
      end
    end else begin
      wv_reg     <= wv_next;
      b0_dat_reg <= b0_dat_next;
      b0_msk_reg <= b0_msk_next;
      for (int i = 0; i < WR_SECOND_CYC; i++) begin
        wa_reg[i] <= wa_next[i];
      end
    end
  end

  // Second beat is taken straight from the pins on the K# rise and the
  // whole burst goes to the write buffer; an all-off mask writes nothing
  assign wr_addr_done = wa_reg[WR_SECOND_CYC-1];
  assign sif.wr_valid = clk_en_i & wv_reg[WR_SECOND_CYC-1];
  assign sif.wr_row   = wr_addr_done[ADDR_W-1:1];
  assign sif.wr_data  = order_beats(wr_addr_done[0],
                                    {dq_in_eff, b0_dat_reg});
  assign sif.wr_mask  = order_mask(wr_addr_done[0],
                                   {lanes_now, b0_msk_reg});

  dbs_store u_store (
    .clk_i  (core_clk_i),
    .srst_i (srst_i),
    .ce_i   (clk_en_i),
    .sp     (sif.store)
  );
endmodule // dbs_core
`default_nettype wire

// [dbs_pkg.sv]
// Shared constants for the burst-of-two DDR SRAM core model.
// Assumes one core clock at twice the K rate: even cycles are K rises,
// odd cycles are K# rises.
package dbs_pkg;

  // Data organisation: four 9-bit lanes, x18 uses the lower two
  localparam int DQ_W      = 36;
  localparam int LANE_W    = 9;
  localparam int LANES     = 4;
  localparam int X18_LANES = 2;
  localparam int X18_W     = X18_LANES * LANE_W;
  localparam int ADDR_W    = 20;
  localparam int ROW_W     = ADDR_W - 1;
  localparam int BURST_W   = 2 * DQ_W;
  localparam int MASK_W    = 2 * LANES;
  localparam int FIFO_DEPTH = 16;

  // Clock periods in ns
  localparam int CORE_PERIOD_NS = 100;
  localparam int K_PERIOD_NS    = 200;

  // Event times in tenths of a K cycle after the read command at t
  localparam int RD_FIRST_KT10  = 15;
  localparam int RD_SECOND_KT10 = 20;
  localparam int WR_CMD_KT10    = 10;
  localparam int WR_FIRST_KT10  = 40;
  localparam int WR_SECOND_KT10 = 45;

  // The same times as core cycles after the own command edge
  localparam int RD_FIRST_CYC  =
    (RD_FIRST_KT10 * K_PERIOD_NS) / (10 * CORE_PERIOD_NS);
  localparam int RD_SECOND_CYC =
    (RD_SECOND_KT10 * K_PERIOD_NS) / (10 * CORE_PERIOD_NS);
  localparam int WR_FIRST_CYC  =
    ((WR_FIRST_KT10 - WR_CMD_KT10) * K_PERIOD_NS) / (10 * CORE_PERIOD_NS);
  localparam int WR_SECOND_CYC =
    ((WR_SECOND_KT10 - WR_CMD_KT10) * K_PERIOD_NS) / (10 * CORE_PERIOD_NS);

  // Reset values
  localparam logic [DQ_W-1:0]   DQ_RST   = 36'h0_0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h0_0000;
  localparam logic [LANES-1:0]  X18_LANE_MASK = 4'h3;

  // Active-high lane enables from active-low strobes, x18 keeps two
  function automatic logic [LANES-1:0] lane_enables(
    input logic [LANES-1:0] lane_n, input logic x18);
    lane_enables = x18 ? (~lane_n & X18_LANE_MASK) : ~lane_n;
  endfunction

  // Exchange the two halves of a burst when the start lsb is one
  function automatic logic [BURST_W-1:0] order_beats(
    input logic lsb, input logic [BURST_W-1:0] b);
    order_beats = lsb ? {b[DQ_W-1:0], b[BURST_W-1:DQ_W]} : b;
  endfunction

  function automatic logic [MASK_W-1:0] order_mask(
    input logic lsb, input logic [MASK_W-1:0] m);
    order_mask = lsb ? {m[LANES-1:0], m[MASK_W-1:LANES]} : m;
  endfunction

  // Lay enabled lanes of new data over old data
  function automatic logic [BURST_W-1:0] merge_lanes(
    input logic [BURST_W-1:0] base, input logic [BURST_W-1:0] data,
    input logic [MASK_W-1:0] mask);
    logic [BURST_W-1:0] r;
    r = base;
    for (int i = 0; i < MASK_W; i++) begin
      if (mask[i]) begin
        r[i*LANE_W +: LANE_W] = data[i*LANE_W +: LANE_W];
      end
    end
    merge_lanes = r;
  endfunction

endpackage

// [dbs_store_if.sv]
// Carrier between the core sequencer and the storage block.
// Assumes both ends sit on the same core clock.
`timescale 1ns/1ns
`default_nettype none
interface dbs_store_if import dbs_pkg::*; ();
  logic               wr_valid;
  logic [ROW_W-1:0]   wr_row;
  logic [BURST_W-1:0] wr_data;
  logic [MASK_W-1:0]  wr_mask;
  logic [ROW_W-1:0]   rd_row;
  logic [BURST_W-1:0] rd_data;

  modport core (output wr_valid, wr_row, wr_data, wr_mask, rd_row,
                input  rd_data);
  modport store (input  wr_valid, wr_row, wr_data, wr_mask, rd_row,
                 output rd_data);
endinterface
`default_nettype wire

// [dbs_fifo.sv]
// Parameterised valid/ready FIFO holding fetched read bursts.
// Assumes a single clock, synchronous reset and a freezing clock enable.
`timescale 1ns/1ns
`default_nettype none
module dbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
  logic [PW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  // Honest flags straight from the occupancy count
  assign in_ready_o  = (cnt_reg != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem[rp_reg];
  assign push = ce_i & in_valid_i & in_ready_o;
  assign pop  = ce_i & out_ready_i & out_valid_o;

  // Pointer and count update
  always_comb begin
    wp_next  = push ? PW'(wp_reg + 1'b1) : wp_reg;
    rp_next  = pop  ? PW'(rp_reg + 1'b1) : rp_reg;
    cnt_next = cnt_reg;
    if (push & ~pop) begin
      cnt_next = (PW+1)'(cnt_reg + 1'b1);
    end else if (pop & ~push) begin
      cnt_next = (PW+1)'(cnt_reg - 1'b1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage needs no reset; only written slots are ever read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_reg] <= in_data_i;
    end
  end
endmodule // dbs_fifo
`default_nettype wire

// [dbs_store.sv]
// Array plus two-burst late-write buffer with read forwarding.
// Assumes one burst write per K cycle at most, from the core sequencer.
`timescale 1ns/1ns
`default_nettype none
module dbs_store import dbs_pkg::*; (
  input  wire logic  clk_i,
  input  wire logic  srst_i,
  input  wire logic  ce_i,
  dbs_store_if.store sp
);
  // Two-word rows; slot 0 holds even addresses
  logic [BURST_W-1:0] mem [0:(2**ROW_W)-1];

  logic [1:0]         bv_reg, bv_next;
  logic [ROW_W-1:0]   brow_reg  [0:1];
  logic [ROW_W-1:0]   brow_next [0:1];
  logic [BURST_W-1:0] bdat_reg  [0:1];
  logic [BURST_W-1:0] bdat_next [0:1];
  logic [MASK_W-1:0]  bmsk_reg  [0:1];
  logic [MASK_W-1:0]  bmsk_next [0:1];
  logic               commit;
  logic [BURST_W-1:0] fwd;

  // A third write retires the oldest buffered burst into the array
  assign commit = ce_i & sp.wr_valid & (bv_reg == 2'b11);

  always_comb begin
    bv_next = bv_reg;
    for (int i = 0; i < 2; i++) begin
      brow_next[i] = brow_reg[i];
      bdat_next[i] = bdat_reg[i];
      bmsk_next[i] = bmsk_reg[i];
    end
    if (ce_i & sp.wr_valid) begin
      if (bv_reg == 2'b11 || bv_reg == 2'b01) begin
        if (bv_reg == 2'b11) begin
          brow_next[0] = brow_reg[1];
          bdat_next[0] = bdat_reg[1];
          bmsk_next[0] = bmsk_reg[1];
        end
        brow_next[1] = sp.wr_row;
        bdat_next[1] = sp.wr_data;
        bmsk_next[1] = sp.wr_mask;
        bv_next      = 2'b11;
      end else begin
        brow_next[0] = sp.wr_row;
        bdat_next[0] = sp.wr_data;
        bmsk_next[0] = sp.wr_mask;
        bv_next      = 2'b01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bv_reg <= 2'b00;
      for (int i = 0; i < 2; i++) begin
        brow_reg[i] <= '0;
        bdat_reg[i] <= '0;
        bmsk_reg[i] <= '0;
      end
    end else begin
      bv_reg <= bv_next;
      for (int i = 0; i < 2; i++) begin
        brow_reg[i] <= brow_next[i];
        bdat_reg[i] <= bdat_next[i];
        bmsk_reg[i] <= bmsk_next[i];
      end
    end
  end

  // Array update, lanes outside the mask keep their old contents
  always_ff @(posedge clk_i) begin
    if (commit) begin
      mem[brow_reg[0]] <= merge_lanes(mem[brow_reg[0]], bdat_reg[0],
                                      bmsk_reg[0]);
    end
  end

  // Newest buffered data wins over older buffer and array
  always_comb begin
    fwd = mem[sp.rd_row];
    for (int i = 0; i < 2; i++) begin
      if (bv_reg[i] && brow_reg[i] == sp.rd_row) begin
        fwd = merge_lanes(fwd, bdat_reg[i], bmsk_reg[i]);
      end
    end
  end
  assign sp.rd_data = fwd;
endmodule // dbs_store
`default_nettype wire

// [dbs_core_chk.sv]
// Port checker for the DDR burst-of-two SRAM core sequencer.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module dbs_core_chk import dbs_pkg::*; (
  input wire logic            core_clk_i,
  input wire logic            srst_i,
  input wire logic            clk_en_i,
  input wire logic            load_new_address_n_i,
  input wire logic            read_not_write_i,
  input wire logic [DQ_W-1:0] dq_o,
  input wire logic            dq_oe_o,
  input wire logic            k_rise_phase_o,
  input wire logic            read_ready_o
);
  logic cmd_take;
  logic rd_take;
  logic wr_take;
  logic nop_take;

  // Command edges: K rise, clock running, out of reset
  assign cmd_take = k_rise_phase_o && clk_en_i && !srst_i;
  assign rd_take  = cmd_take && !load_new_address_n_i && read_not_write_i
                    && read_ready_o;
  assign wr_take  = cmd_take && !load_new_address_n_i && !read_not_write_i;
  assign nop_take = cmd_take && load_new_address_n_i;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  rd_launch_a: assert property (
    rd_take ##1 clk_en_i [*3] |=> dq_oe_o ##1 dq_oe_o)
    else $error("read burst not driven on time");
  // Drivers on only in the two beats owed to a read
  oe_cause_a: assert property (
    dq_oe_o && clk_en_i |-> $past(rd_take, 4) || $past(rd_take, 5))
    else $error("bus driven without a read");
  wr_quiet_a: assert property (
    wr_take ##1 clk_en_i [*3] |=> !dq_oe_o ##1 !dq_oe_o)
    else $error("bus driven after a write");
  nop_quiet_a: assert property (
    nop_take |-> ##4 !dq_oe_o [*2])
    else $error("bus driven after a no-operation");
  stop_hold_a: assert property (
    !clk_en_i |=> $stable(dq_o) && $stable(dq_oe_o)
      && $stable(k_rise_phase_o))
    else $error("state moved with clock stopped");
  phase_step_a: assert property (
    clk_en_i |=> k_rise_phase_o != $past(k_rise_phase_o))
    else $error("K phase did not alternate");
  hold_idle_a: assert property (
    !dq_oe_o |=> $stable(dq_o) || dq_oe_o)
    else $error("read data changed while idle");
  // Reset must leave the bus released and the phase on a K rise
  reset_idle_a: assert property (disable iff (1'b0)
    srst_i |=> !dq_oe_o && k_rise_phase_o && dq_o == DQ_RST)
    else $error("reset state wrong");

  cover property (rd_take ##2 rd_take);
  cover property (wr_take ##2 wr_take);
  cover property (!clk_en_i [*8]);
endmodule // dbs_core_chk

bind dbs_core dbs_core_chk i_dbs_core_chk (
  .core_clk_i(core_clk_i),
  .srst_i(srst_i),
  .clk_en_i(clk_en_i),
  .load_new_address_n_i(load_new_address_n_i),
  .read_not_write_i(read_not_write_i),
  .dq_o(dq_o),
  .dq_oe_o(dq_oe_o),
  .k_rise_phase_o(k_rise_phase_o),
  .read_ready_o(read_ready_o)
);
`default_nettype wire

// [dbs_ctrl_model.sv]
// Controller model: queued commands, late write data, refused noise.
// Assumes the device's core clock and its K-rise phase flag.
`timescale 1ns/1ns
`default_nettype none
module dbs_ctrl_model import dbs_pkg::*; (
  input  wire logic              clk_i,
  input  wire logic              k_rise_i,
  output logic                   load_n_o,
  output logic                   rnw_o,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [LANES-1:0]  lane_n_o,
  output logic      [DQ_W-1:0]   dq_o
);
  // Kind 0 write, 1 read, 2 no-operation; beat 1 in the upper halves
  typedef struct {
    int                 kind;
    logic [ADDR_W-1:0]  a;
    logic [BURST_W-1:0] d;
    logic [MASK_W-1:0]  m;
  } dbs_cmd_t;

  dbs_cmd_t              cmd_q[$];
  logic [DQ_W+LANES:0]   slot[16];
  int                    cyc = 0;

  // Quiet pins at time zero
  initial begin
    load_n_o = 1'b1;
    rnw_o    = 1'b0;
    addr_o   = '0;
    lane_n_o = '1;
    dq_o     = '0;
    foreach (slot[i]) slot[i] = '0;
  end

  // Act one step after each edge so the device samples settled pins
  always @(posedge clk_i) begin
    dbs_cmd_t c;
    #1;
    cyc = cyc + 1;
    if (k_rise_i && cmd_q.size() > 0) begin
      c = cmd_q.pop_front();
      load_n_o = (c.kind == 2);
      rnw_o    = (c.kind == 1);
      addr_o   = c.a;
      if (c.kind == 0) begin
        slot[(cyc + 6) % 16] = {1'b1, c.m[3:0], c.d[35:0]};
        slot[(cyc + 7) % 16] = {1'b1, c.m[7:4], c.d[71:36]};
      end
    end else begin
      // K# cycles carry a command the device has to refuse
      load_n_o = k_rise_i;
      rnw_o    = ~rnw_o;
      addr_o   = ~addr_o;
    end
    if (slot[cyc % 16][DQ_W+LANES]) begin
      {lane_n_o, dq_o} = slot[cyc % 16][DQ_W+LANES-1:0];
      slot[cyc % 16]   = '0;
    end else begin
      // Released bus shows the inverse, never a stale value
      lane_n_o = ~lane_n_o;
      dq_o     = ~dq_o;
    end
  end
endmodule // dbs_ctrl_model
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the DDR burst-of-two SRAM core sequencer.
// Assumes dbs_ctrl_model as far side; x36 runs time reads from K and K#,
// x18 runs use C and C# clocks that follow the K phase.
`timescale 1ns/1ns
`default_nettype none
module testbench import dbs_pkg::*;;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic              clk_en = 1'b1;
  logic              x18 = 1'b0;
  logic              kmode = 1'b1;
  logic              load_n, rnw, oe, kph, rrdy;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0]  lane_n;
  logic [DQ_W-1:0]   m_dq, dq_in, dq_out, last_rd;
  logic [DQ_W-1:0]   mem[logic [ADDR_W-1:0]];
  logic [DQ_W-1:0]   exp_q[$];
  logic [DQ_W-1:0]   msk_q[$];
  logic [ADDR_W-1:0] ta[6];
  int                fail_count = 0;
  int                checks_done = 0;
  int                seed = 32'h2d28_220c;
  int                slot = 0;
  int                last_wr = -9;

  // 10 MHz core clock
  always #50 clk = ~clk;
  // Common data bus: the device wins only while its drivers are on
  assign dq_in = oe ? dq_out : m_dq;

  dbs_core i_dbs_core (
    .core_clk_i(clk),
    .srst_i(srst),
    .clk_en_i(clk_en),
    .load_new_address_n_i(load_n),
    .read_not_write_i(rnw),
    .addr_i(addr),
    .byte_lane0_write_en_n_i(lane_n[0]),
    .byte_lane1_write_en_n_i(lane_n[1]),
    .byte_lane2_write_en_n_i(lane_n[2]),
    .byte_lane3_write_en_n_i(lane_n[3]),
    .dq_i(dq_in),
    .c_i(kmode | kph),
    .c_n_i(kmode | ~kph),
    .out_clk_tied_high_i(kmode),
    .org_x18_i(x18),
    .dq_o(dq_out),
    .dq_oe_o(oe),
    .k_rise_phase_o(kph),
    .read_ready_o(rrdy)
  );

  dbs_ctrl_model i_dbs_ctrl_model (
    .clk_i(clk),
    .k_rise_i(kph),
    .load_n_o(load_n),
    .rnw_o(rnw),
    .addr_o(addr),
    .lane_n_o(lane_n),
    .dq_o(m_dq)
  );

  task automatic check(input logic [DQ_W-1:0] seen, input logic [DQ_W-1:0] ex);
    checks_done++;
    if (seen !== ex) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, ex);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Reference memory: only enabled lanes take new data
  task automatic mem_wr(input logic [ADDR_W-1:0] a, input logic [DQ_W-1:0] d,
                        input logic [LANES-1:0] m);
    for (int i = 0; i < LANES; i++) begin
      if (!m[i] && (!x18 || i < X18_LANES)) begin
        mem[a][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
      end
    end
  endtask

  task automatic nop();
    i_dbs_ctrl_model.cmd_q.push_back('{2, ADDR_W'($random(seed)), '0, '0});
    slot++;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [MASK_W-1:0] m);
    logic [DQ_W-1:0] d0;
    logic [DQ_W-1:0] d1;
    d0 = DQ_W'({$random(seed), $random(seed)});
    d1 = DQ_W'({$random(seed), $random(seed)});
    i_dbs_ctrl_model.cmd_q.push_back('{0, a, {d1, d0}, m});
    mem_wr(a, d0, m[3:0]);
    mem_wr(a ^ 20'h0_0001, d1, m[7:4]);
    last_wr = slot;
    slot++;
  endtask

  // A read keeps four K slots behind a write so its data has landed
  task automatic rd(input logic [ADDR_W-1:0] a);
    while (slot - last_wr < 4) begin
      nop();
    end
    i_dbs_ctrl_model.cmd_q.push_back('{1, a, '0, '0});
    exp_q.push_back(mem[a]);
    exp_q.push_back(mem[a ^ 20'h0_0001]);
    repeat (2) msk_q.push_back(x18 ? 36'h0_0003_ffff : 36'hf_ffff_ffff);
    slot++;
  endtask

  task automatic drain(input string name);
    for (int i = 0; i < 400 && (exp_q.size() > 0 ||
         i_dbs_ctrl_model.cmd_q.size() > 0); i++) @(posedge clk);
    repeat (12) @(posedge clk);
    check(DQ_W'(exp_q.size()), '0);
    $display("Test %s done", name);
  endtask

  task automatic do_reset(input logic org);
    @(posedge clk);
    #1;
    srst = 1'b1;
    x18  = org;
    kmode = ~org;
    repeat (20) @(posedge clk);
    #1;
    srst = 1'b0;
  endtask

  // Full write, then every lane pattern on both beats, each read back
  task automatic lanes(input logic [ADDR_W-1:0] a);
    wr(a, '0);
    for (int m = 0; m < 16; m++) begin
      wr(a, {~4'(m), 4'(m)});
      rd(a);
    end
  endtask

  // Score each driven read beat against the oldest note; mid-cycle
  // sampling keeps clear of the edge that launches the beat
  always @(negedge clk) begin
    logic [DQ_W-1:0] mk;
    if (!srst && clk_en && oe) begin
      if (exp_q.size() == 0) check({35'h0, oe}, '0);
      else begin
        mk = msk_q.pop_front();
        check(dq_out & mk, exp_q.pop_front() & mk);
      end
      last_rd = dq_out;
    end
  end

  // Main sequence
  initial begin
    do_reset(1'b0);
    for (int i = 0; i < 6; i++) begin
      ta[i] = ADDR_W'($random(seed)) & 20'h7_ffff;
      wr(ta[i], '0);
    end
    for (int i = 0; i < 6; i++) begin
      rd(ta[i]);
      if (i % 2 == 1) nop();
    end
    drain("burst order");
    lanes(20'h0_0101);
    drain("byte lanes");
    @(posedge clk);
    #1;
    clk_en = 1'b0;
    repeat (10) @(posedge clk);
    check(dq_out, last_rd);
    check({35'h0, oe}, '0);
    #1;
    clk_en = 1'b1;
    rd(ta[0]);
    drain("clock stop");
    do_reset(1'b1);
    check(dq_out, DQ_RST);
    lanes(20'h8_0200);
    drain("x18 lanes");
    end_of_test();
  end

  // Cut a hang short far beyond the expected run of some 500 cycles
  initial begin
    #(CORE_PERIOD_NS * 20000);
    fail_count++;
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
